//--- hdl/cmd_pkg.sv
// constants and helpers shared by the command decode block
package cmd_pkg;
   // opcodes handled here
   localparam logic [7:0] OP_IRQ_ENABLE = 8'h19;   // 25
   localparam logic [7:0] OP_IRQ_DISABLE = 8'h1a;  // 26
   localparam logic [7:0] OP_ACCU_TO_GP = 8'h23;   // 35
   localparam logic [7:0] OP_CLEAR_FLAGS = 8'h24;  // 36
   localparam logic [7:0] OP_DEFINE_VEC = 8'h25;   // 37
   localparam logic [7:0] OP_RETURN_HNDL = 8'h26;  // 38
   // type field codes
   localparam logic [7:0] IRQ_GLOBAL = 8'hff;
   localparam logic [7:0] CLR_ALL = 8'h00;
   localparam logic [7:0] CLR_LAST = 8'h05;
   // legal banks of the accumulator copy
   localparam logic [7:0] BANK_0 = 8'h00;
   localparam logic [7:0] BANK_2 = 8'h02;
   localparam logic [7:0] BANK_3 = 8'h03;
   // reply status codes
   localparam logic [7:0] STATUS_OK = 8'h64;
   localparam logic [7:0] STATUS_CSUM_ERR = 8'h01;
   // error flag bit positions
   localparam int FLAG_W = 5;
   localparam int FLAG_TIMEOUT = 0;
   localparam int FLAG_ALARM = 1;
   localparam int FLAG_DEVIATION = 2;
   localparam int FLAG_POSITION = 3;
   localparam int FLAG_SHUTDOWN = 4;
   // register word offsets
   localparam logic [7:0] REG_EVENT_STATUS = 8'h00;
   localparam logic [7:0] REG_EVENT_MASK = 8'h04;
   localparam logic [7:0] REG_ERROR_FLAGS = 8'h08;
   localparam logic [7:0] REG_IRQ_GLOBAL = 8'h0c;
   localparam logic [7:0] REG_IRQ_SOURCES = 8'h10;
   // event status bit positions
   localparam int EV_W = 4;
   localparam int EV_CMD_DONE = 0;
   localparam int EV_CSUM_ERR = 1;
   localparam int EV_FLAG_SET = 2;
   localparam int EV_BANK_BAD = 3;
   // reset values
   localparam logic [EV_W-1:0] EVENT_MASK_RST = 4'h0;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 5'h00;
   localparam logic [7:0] CTX_FLAGS_W = 8'h08;

   // low byte of the sum of address, opcode, type, bank and value bytes
   function automatic logic [7:0] frame_sum8(input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] c, input logic [7:0] d,
      input logic [31:0] v);
      frame_sum8 = a + b + c + d + v[31:24] + v[23:16] + v[15:8] + v[7:0];
   endfunction : frame_sum8
endpackage : cmd_pkg

//--- hdl/handler_vector_mem.sv
// handler entry address table, one write port, registered read
module handler_vector_mem
   import cmd_pkg::*;
#(
   parameter int DEPTH = 32,
   parameter int WIDTH = 32
) (
   // clock
   input wire logic clk_sys,
   // write port
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read port
   input wire logic rd_en,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data_r
);
   logic [WIDTH-1:0] mem [DEPTH];

   initial begin
      if (DEPTH < 2) $error("handler_vector_mem: DEPTH below 2");
   end

   // no reset on the array so it maps onto ram; read output is a flop
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rd_en) begin
         rd_data_r <= mem[rd_addr];
      end
   end
endmodule : handler_vector_mem

//--- hdl/flag_and_irq_command_decode.sv
// decode and execute flag, interrupt and accumulator-copy commands
//
// Added by the designer: the address map and the address-and-strobe port.
module flag_and_irq_command_decode
   import cmd_pkg::*;
#(
   parameter int NUM_IRQ = 32,
   parameter int VEC_W = 32,
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter logic [7:0] HOST_ADDR = 8'h02
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // command in
   input wire logic cmd_valid,
   input wire logic cmd_from_program,
   input wire logic [7:0] cmd_addr,
   input wire logic [7:0] cmd_opcode,
   input wire logic [7:0] cmd_type,
   input wire logic [7:0] cmd_bank,
   input wire logic [31:0] cmd_value,
   input wire logic [7:0] cmd_checksum,
   // core state
   input wire logic [31:0] accu_in,
   input wire logic [FLAG_W-1:0] err_set,
   // context saved at handler entry
   input wire logic ctx_save,
   input wire logic [31:0] ctx_accu,
   input wire logic [31:0] ctx_x,
   input wire logic [7:0] ctx_flags,
   input wire logic [VEC_W-1:0] ctx_pc,
   // vector lookup
   input wire logic vec_rd_en,
   input wire logic [$clog2(NUM_IRQ)-1:0] vec_rd_num,
   output logic [VEC_W-1:0] vec_rd_data_r,
   // global parameter write
   output logic gp_wr_r,
   output logic [7:0] gp_bank_r,
   output logic [7:0] gp_index_r,
   output logic [31:0] gp_data_r,
   // flags and interrupt enables
   output logic [FLAG_W-1:0] err_flags_r,
   output logic [NUM_IRQ-1:0] irq_src_en_r,
   output logic irq_glob_en_r,
   output logic in_handler_r,
   // context restore
   output logic restore_valid_r,
   output logic [31:0] restore_accu_r,
   output logic [31:0] restore_x_r,
   output logic [7:0] restore_flags_r,
   output logic [VEC_W-1:0] restore_pc_r,
   // reply
   output logic reply_valid_r,
   output logic [7:0] reply_status_r,
   output logic [7:0] reply_opcode_r,
   output logic [7:0] reply_checksum_r,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata_r,
   output logic irq_r
);
   localparam int IRQ_W = $clog2(NUM_IRQ);
   localparam logic [7:0] IRQ_LIM = 8'(NUM_IRQ);

   initial begin
      if (NUM_IRQ < 2 || NUM_IRQ > 255) $error("NUM_IRQ out of 2..255");
      if (VEC_W < 1 || VEC_W > 32) $error("VEC_W out of 1..32");
   end

   logic csum_ok;
   logic exec;
   logic irq_num_ok;
   logic bank_ok;
   logic [FLAG_W-1:0] clr_mask;
   logic [FLAG_W-1:0] err_flags_nxt;
   logic [EV_W-1:0] ev_status_r;
   logic [EV_W-1:0] ev_mask_r;
   logic [EV_W-1:0] ev_set;
   logic [31:0] saved_accu_r;
   logic [31:0] saved_x_r;
   logic [7:0] saved_flags_r;
   logic [VEC_W-1:0] saved_pc_r;
   logic [255:0] src_ext;

   // frames for another address are not ours and are dropped silently
   assign csum_ok = frame_sum8(cmd_addr, cmd_opcode, cmd_type, cmd_bank,
      cmd_value) == cmd_checksum;
   assign exec = cmd_valid && cmd_addr == MODULE_ADDR && csum_ok;
   assign irq_num_ok = cmd_type < IRQ_LIM;
   assign bank_ok = cmd_bank == BANK_0 || cmd_bank == BANK_2 ||
      cmd_bank == BANK_3;

   always_comb begin
      clr_mask = '0;
      if (exec && cmd_opcode == OP_CLEAR_FLAGS) begin
         if (cmd_type == CLR_ALL) begin
            clr_mask = '1;
         end else if (cmd_type <= CLR_LAST) begin
            clr_mask[3'(cmd_type - 8'h01)] = 1'b1;
         end
      end
   end

   // a flag raised in the clearing cycle survives
   assign err_flags_nxt = (err_flags_r & ~clr_mask) | err_set;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         err_flags_r <= FLAGS_RST;
      end else begin
         err_flags_r <= err_flags_nxt;
      end
   end

   // accumulator to global parameter
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gp_wr_r <= 1'b0;
         gp_bank_r <= 8'h00;
         gp_index_r <= 8'h00;
         gp_data_r <= 32'h0;
      end else begin
         gp_wr_r <= exec && cmd_opcode == OP_ACCU_TO_GP && bank_ok;
         if (exec && cmd_opcode == OP_ACCU_TO_GP && bank_ok) begin
            gp_bank_r <= cmd_bank;
            gp_index_r <= cmd_type;
            gp_data_r <= accu_in;
         end
      end
   end

   // interrupt enables; 255 acts on the global switch only
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irq_src_en_r <= '0;
         irq_glob_en_r <= 1'b0;
      end else if (exec && cmd_opcode == OP_IRQ_ENABLE) begin
         if (cmd_type == IRQ_GLOBAL) begin
            irq_glob_en_r <= 1'b1;
         end else if (irq_num_ok) begin
            irq_src_en_r[cmd_type[IRQ_W-1:0]] <= 1'b1;
         end
      end else if (exec && cmd_opcode == OP_IRQ_DISABLE) begin
         if (cmd_type == IRQ_GLOBAL) begin
            irq_glob_en_r <= 1'b0;
         end else if (irq_num_ok) begin
            irq_src_en_r[cmd_type[IRQ_W-1:0]] <= 1'b0;
         end
      end
   end

   // the table trusts the issuer to send definitions from the program
   handler_vector_mem #(
      .DEPTH(NUM_IRQ),
      .WIDTH(VEC_W)
   ) u_vec_mem (
      .clk_sys(clk_sys),
      .wr_en(exec && cmd_opcode == OP_DEFINE_VEC && irq_num_ok),
      .wr_addr(cmd_type[IRQ_W-1:0]),
      .wr_data(cmd_value[VEC_W-1:0]),
      .rd_en(vec_rd_en),
      .rd_addr(vec_rd_num),
      .rd_data_r(vec_rd_data_r)
   );

   // context saved at entry and handed back on return
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         saved_accu_r <= 32'h0;
         saved_x_r <= 32'h0;
         saved_flags_r <= 8'h00;
         saved_pc_r <= '0;
      end else if (ctx_save) begin
         saved_accu_r <= ctx_accu;
         saved_x_r <= ctx_x;
         saved_flags_r <= ctx_flags;
         saved_pc_r <= ctx_pc;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         restore_valid_r <= 1'b0;
         restore_accu_r <= 32'h0;
         restore_x_r <= 32'h0;
         restore_flags_r <= 8'h00;
         restore_pc_r <= '0;
      end else begin
         restore_valid_r <= exec && cmd_opcode == OP_RETURN_HNDL;
         if (exec && cmd_opcode == OP_RETURN_HNDL) begin
            restore_accu_r <= saved_accu_r;
            restore_x_r <= saved_x_r;
            restore_flags_r <= saved_flags_r;
            restore_pc_r <= saved_pc_r;
         end
      end
   end

   // entry wins over a return in the same cycle
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         in_handler_r <= 1'b0;
      end else if (ctx_save) begin
         in_handler_r <= 1'b1;
      end else if (exec && cmd_opcode == OP_RETURN_HNDL) begin
         in_handler_r <= 1'b0;
      end
   end

   // direct mode reply; a bad checksum still earns an answer
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reply_valid_r <= 1'b0;
         reply_status_r <= 8'h00;
         reply_opcode_r <= 8'h00;
         reply_checksum_r <= 8'h00;
      end else begin
         reply_valid_r <= cmd_valid && !cmd_from_program &&
            cmd_addr == MODULE_ADDR;
         if (cmd_valid && !cmd_from_program && cmd_addr == MODULE_ADDR) begin
            reply_status_r <= csum_ok ? STATUS_OK : STATUS_CSUM_ERR;
            reply_opcode_r <= cmd_opcode;
            reply_checksum_r <= frame_sum8(HOST_ADDR, MODULE_ADDR,
               csum_ok ? STATUS_OK : STATUS_CSUM_ERR, cmd_opcode,
               32'h0);
         end
      end
   end

   // events: sticky, write one to clear, set beats clear
   always_comb begin
      ev_set = '0;
      ev_set[EV_CMD_DONE] = exec;
      ev_set[EV_CSUM_ERR] = cmd_valid && cmd_addr == MODULE_ADDR && !csum_ok;
      ev_set[EV_FLAG_SET] = |(err_set & ~err_flags_r);
      ev_set[EV_BANK_BAD] = exec && cmd_opcode == OP_ACCU_TO_GP && !bank_ok;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ev_status_r <= '0;
      end else if (reg_wr && reg_addr == REG_EVENT_STATUS) begin
         ev_status_r <= (ev_status_r & ~reg_wdata[EV_W-1:0]) | ev_set;
      end else begin
         ev_status_r <= ev_status_r | ev_set;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ev_mask_r <= EVENT_MASK_RST;
      end else if (reg_wr && reg_addr == REG_EVENT_MASK) begin
         ev_mask_r <= reg_wdata[EV_W-1:0];
      end
   end

   // one cycle behind the status bit so the pin leaves a flop
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(ev_status_r & ev_mask_r);
      end
   end

   // only the low 32 source enables are visible to software
   assign src_ext = 256'(irq_src_en_r);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata_r <= 32'h0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_EVENT_STATUS: reg_rdata_r <= 32'(ev_status_r);
            REG_EVENT_MASK: reg_rdata_r <= 32'(ev_mask_r);
            REG_ERROR_FLAGS: reg_rdata_r <= 32'(err_flags_r);
            REG_IRQ_GLOBAL: reg_rdata_r <= 32'(irq_glob_en_r);
            REG_IRQ_SOURCES: reg_rdata_r <= src_ext[31:0];
            default: reg_rdata_r <= 32'h0;
         endcase
      end else begin
         reg_rdata_r <= 32'h0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_copy;
      exec && cmd_opcode == OP_ACCU_TO_GP && bank_ok;
   endsequence
   sequence s_enable_one;
      exec && cmd_opcode == OP_IRQ_ENABLE && irq_num_ok;
   endsequence
   sequence s_disable_one;
      exec && cmd_opcode == OP_IRQ_DISABLE && irq_num_ok;
   endsequence

   AST_COPY_ACCU: assert property (
      s_copy |=> gp_wr_r && gp_data_r == $past(accu_in) &&
         gp_index_r == $past(cmd_type))
      else $error("accumulator copy not issued");
   AST_COPY_BANK: assert property (
      gp_wr_r |-> gp_bank_r == BANK_0 || gp_bank_r == BANK_2 ||
         gp_bank_r == BANK_3)
      else $error("global write to illegal bank");
   AST_CLEAR_ALL: assert property (
      exec && cmd_opcode == OP_CLEAR_FLAGS && cmd_type == CLR_ALL
      |=> err_flags_r == $past(err_set))
      else $error("clear all left a flag");
   AST_CLEAR_KEEP: assert property (
      exec && cmd_opcode == OP_CLEAR_FLAGS && cmd_type == 8'h01
      |=> err_flags_r[FLAG_SHUTDOWN:FLAG_ALARM] ==
         ($past(err_flags_r[FLAG_SHUTDOWN:FLAG_ALARM]) |
          $past(err_set[FLAG_SHUTDOWN:FLAG_ALARM])) &&
         err_flags_r[FLAG_TIMEOUT] == $past(err_set[FLAG_TIMEOUT]))
      else $error("timeout clear touched other flags");
   AST_ENABLE_ONE: assert property (
      s_enable_one |=> irq_src_en_r[$past(cmd_type[IRQ_W-1:0])] &&
         $stable(irq_glob_en_r))
      else $error("source not enabled");
   AST_ENABLE_ALL: assert property (
      exec && cmd_opcode == OP_IRQ_ENABLE && cmd_type == IRQ_GLOBAL
      |=> irq_glob_en_r && $stable(irq_src_en_r))
      else $error("global enable failed");
   AST_DISABLE_ONE: assert property (
      s_disable_one |=> !irq_src_en_r[$past(cmd_type[IRQ_W-1:0])])
      else $error("source not disabled");
   AST_DISABLE_ALL: assert property (
      exec && cmd_opcode == OP_IRQ_DISABLE && cmd_type == IRQ_GLOBAL
      |=> !irq_glob_en_r ##1 !irq_glob_en_r || $past(cmd_opcode) ==
         OP_IRQ_ENABLE)
      else $error("global disable failed");

   property p_vector;
      logic [VEC_W-1:0] a;
      logic [IRQ_W-1:0] n;
      (exec && cmd_opcode == OP_DEFINE_VEC && irq_num_ok,
         a = cmd_value[VEC_W-1:0], n = cmd_type[IRQ_W-1:0])
      ##1 (vec_rd_en && vec_rd_num == n &&
         !(exec && cmd_opcode == OP_DEFINE_VEC))
      |=> vec_rd_data_r == a;
   endproperty
   AST_VECTOR_STORE: assert property (p_vector)
      else $error("handler entry not stored");
   AST_RESTORE: assert property (
      exec && cmd_opcode == OP_RETURN_HNDL |=> restore_valid_r &&
         restore_pc_r == $past(saved_pc_r) &&
         restore_accu_r == $past(saved_accu_r) ##1 !restore_valid_r ||
         $past(exec))
      else $error("context not restored");
   AST_REPLY_OK: assert property (
      exec && !cmd_from_program |=> reply_valid_r &&
         reply_status_r == STATUS_OK)
      else $error("direct command not answered ok");
   AST_REPLY_SUM: assert property (
      reply_valid_r |-> reply_checksum_r == 8'(HOST_ADDR + MODULE_ADDR +
         reply_status_r + reply_opcode_r))
      else $error("reply checksum wrong");
endmodule : flag_and_irq_command_decode

//--- bench/cmd_issuer.sv
// command issuer standing in for the host or the stored program
module cmd_issuer
   import cmd_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // command out
   output logic cmd_valid,
   output logic cmd_from_program,
   output logic [7:0] cmd_addr,
   output logic [7:0] cmd_opcode,
   output logic [7:0] cmd_type,
   output logic [7:0] cmd_bank,
   output logic [31:0] cmd_value,
   output logic [7:0] cmd_checksum
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cmd_valid = 1'b0;
      cmd_from_program = 1'b0;
      cmd_addr = 8'h00;
      cmd_opcode = 8'h00;
      cmd_type = 8'h00;
      cmd_bank = 8'h00;
      cmd_value = 32'h0;
      cmd_checksum = 8'h00;
   end

   // one frame, held for exactly one taking edge
   task automatic send(input logic [7:0] op, input logic [7:0] typ,
      input logic [7:0] bank, input logic [31:0] val, input bit prog,
      input bit corrupt, input logic [7:0] addr);
      int sum;
      sum = addr + op + typ + bank + val[31:24] + val[23:16]
         + val[15:8] + val[7:0];
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      // handler vectors only ever come from the stored program
      cmd_from_program <= prog | (op == OP_DEFINE_VEC);
      cmd_addr <= addr;
      cmd_opcode <= op;
      cmd_type <= typ;
      cmd_bank <= bank;
      cmd_value <= val;
      cmd_checksum <= sum[7:0] ^ {7'h00, corrupt};
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      // released fields must not look like the last frame
      cmd_addr <= ~addr;
      cmd_opcode <= ~op;
      cmd_type <= ~typ;
      cmd_bank <= ~bank;
      cmd_value <= ~val;
      cmd_checksum <= ~sum[7:0];
   endtask : send
endmodule : cmd_issuer

//--- bench/test_flag_and_irq_command_decode.sv
// self-checking bench for the flag and interrupt command decoder
module test_flag_and_irq_command_decode;
   import cmd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NIRQ = 32;
   localparam logic [7:0] MOD_A = 8'h01;
   localparam logic [7:0] HOST_A = 8'h02;
   logic clk_sys, reset_n, cmd_valid, cmd_from_program;
   logic [7:0] cmd_addr, cmd_opcode, cmd_type, cmd_bank, cmd_checksum;
   logic [31:0] cmd_value, accu_in, accu_q, ctx_accu, ctx_x;
   logic [FLAG_W-1:0] err_set, err_flags_r;
   logic ctx_save, vec_rd_en, gp_wr_r, irq_glob_en_r, in_handler_r;
   logic [7:0] ctx_flags, gp_bank_r, gp_index_r, restore_flags_r;
   logic [31:0] ctx_pc, vec_rd_data_r, gp_data_r, restore_accu_r;
   logic [31:0] restore_x_r, restore_pc_r, reg_wdata, reg_rdata_r;
   logic [4:0] vec_rd_num;
   logic [NIRQ-1:0] irq_src_en_r;
   logic restore_valid_r, reply_valid_r, reg_wr, reg_rd, irq_r;
   logic [7:0] reply_status_r, reply_opcode_r, reply_checksum_r, reg_addr;
   int seed = 35;
   int fail_count = 0;
   int tests_run = 0;
   int m_flags = 0;
   int m_glob = 0;
   bit [NIRQ-1:0] m_src = '0;
   logic [31:0] m_vec[int];
   logic [31:0] m_ctx[4];

   flag_and_irq_command_decode #(.NUM_IRQ(NIRQ), .VEC_W(32),
      .MODULE_ADDR(MOD_A), .HOST_ADDR(HOST_A))
   flag_and_irq_command_decode_inst (.clk_sys, .reset_n, .cmd_valid,
      .cmd_from_program, .cmd_addr, .cmd_opcode, .cmd_type, .cmd_bank,
      .cmd_value, .cmd_checksum, .accu_in, .err_set, .ctx_save,
      .ctx_accu, .ctx_x, .ctx_flags, .ctx_pc, .vec_rd_en, .vec_rd_num,
      .vec_rd_data_r, .gp_wr_r, .gp_bank_r, .gp_index_r, .gp_data_r,
      .err_flags_r, .irq_src_en_r, .irq_glob_en_r, .in_handler_r,
      .restore_valid_r, .restore_accu_r, .restore_x_r, .restore_flags_r,
      .restore_pc_r, .reply_valid_r, .reply_status_r, .reply_opcode_r,
      .reply_checksum_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_r, .irq_r);

   cmd_issuer cmd_issuer_inst (.clk_sys, .cmd_valid, .cmd_from_program,
      .cmd_addr, .cmd_opcode, .cmd_type, .cmd_bank, .cmd_value,
      .cmd_checksum);

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // accumulator wanders every cycle; accu_q is what a taking edge saw
   always @(posedge clk_sys) begin
      accu_in <= $random(seed);
      accu_q <= accu_in;
   end

   task automatic check(input string name, input logic [63:0] seen,
      input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(negedge clk_sys);
      d = reg_rdata_r;
   endtask : reg_read

   // update the model, issue one frame, compare reply, copy, restore, flags, enables and vector
   task automatic cmd(input logic [7:0] op, input logic [7:0] typ,
      input logic [7:0] bank, input logic [31:0] val, input bit prog);
      bit ok;
      ok = op == OP_ACCU_TO_GP && bank inside {BANK_0, BANK_2, BANK_3};
      if (op == OP_CLEAR_FLAGS && typ == CLR_ALL) m_flags = 0;
      else if (op == OP_CLEAR_FLAGS && typ <= CLR_LAST)
         m_flags = m_flags & ~(1 << (typ - 1));
      if (op == OP_IRQ_ENABLE || op == OP_IRQ_DISABLE) begin
         if (typ == IRQ_GLOBAL) m_glob = (op == OP_IRQ_ENABLE);
         else if (typ < NIRQ) m_src[typ] = (op == OP_IRQ_ENABLE);
      end
      if (op == OP_DEFINE_VEC && typ < NIRQ) m_vec[typ] = val;
      cmd_issuer_inst.send(op, typ, bank, val, prog, 1'b0, MOD_A);
      // read back in the very next cycle, right behind the table write
      if (op == OP_DEFINE_VEC && typ < NIRQ) begin
         vec_rd_en <= 1'b1;
         vec_rd_num <= typ[4:0];
      end
      @(negedge clk_sys);
      check("reply_valid", reply_valid_r, !prog);
      if (!prog) begin
         check("reply_status", reply_status_r, STATUS_OK);
         check("reply_sum", reply_checksum_r,
            8'(HOST_A + MOD_A + STATUS_OK + op));
         check("reply_op", reply_opcode_r, op);
      end
      check("gp_wr", gp_wr_r, ok);
      if (ok) begin
         check("gp_bank", gp_bank_r, bank);
         check("gp_index", gp_index_r, typ);
         check("gp_data", gp_data_r, accu_q);
      end
      check("restore", restore_valid_r, op == OP_RETURN_HNDL);
      if (op == OP_RETURN_HNDL) begin
         check("rst_accu", restore_accu_r, m_ctx[0]);
         check("rst_x", restore_x_r, m_ctx[1]);
         check("rst_flags", restore_flags_r, m_ctx[2][7:0]);
         check("rst_pc", restore_pc_r, m_ctx[3]);
         check("in_handler", in_handler_r, 1'b0);
      end
      check("flags", err_flags_r, m_flags);
      check("src_en", irq_src_en_r, m_src);
      check("glob_en", irq_glob_en_r, m_glob);
      if (op == OP_DEFINE_VEC && typ < NIRQ) begin
         @(posedge clk_sys);
         vec_rd_en <= 1'b0;
         @(negedge clk_sys);
         check("vector", vec_rd_data_r, m_vec[typ]);
      end
   endtask : cmd

   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      conclude();
   end

   initial begin
      int nums[6] = '{0, 31, 32, 7, 255, 19};
      int banks[5] = '{0, 1, 2, 3, 4};
      logic [31:0] d;
      reset_n = 1'b0;
      err_set = '0;
      ctx_save = 1'b0;
      {ctx_accu, ctx_x, ctx_flags, ctx_pc} = '0;
      vec_rd_en = 1'b0;
      vec_rd_num = '0;
      {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      check("rst_flags", err_flags_r, 5'h00);
      check("rst_irq", irq_r, 1'b0);
      reg_read(REG_EVENT_MASK, d);
      check("rst_mask", d, EVENT_MASK_RST);
      foreach (banks[i])
         cmd(OP_ACCU_TO_GP, 8'($random(seed)), 8'(banks[i]),
            $random(seed), banks[i] % 2);
      $display("test accumulator copy done");
      for (int c = 0; c <= 6; c++) begin
         @(posedge clk_sys);
         err_set <= 5'h1f;
         @(posedge clk_sys);
         err_set <= 5'h00;
         m_flags = 31;
         cmd(OP_CLEAR_FLAGS, 8'(c), 8'($random(seed)), $random(seed),
            c % 2);
      end
      $display("test flag clear done");
      foreach (nums[i]) cmd(OP_IRQ_ENABLE, 8'(nums[i]), 0, 0, i % 2);
      foreach (nums[i]) cmd(OP_IRQ_DISABLE, 8'(nums[i]), 0, 0, 0);
      cmd(OP_IRQ_ENABLE, IRQ_GLOBAL, 0, 0, 0);
      $display("test interrupt enables done");
      cmd(OP_DEFINE_VEC, 8'd3, 0, $random(seed), 1'b1);
      cmd(OP_DEFINE_VEC, 8'd3, 0, $random(seed), 1'b1);
      cmd(OP_DEFINE_VEC, 8'd31, 0, $random(seed), 1'b1);
      $display("test handler vectors done");
      foreach (m_ctx[i]) m_ctx[i] = $random(seed);
      @(posedge clk_sys);
      ctx_save <= 1'b1;
      {ctx_accu, ctx_x, ctx_flags, ctx_pc} <=
         {m_ctx[0], m_ctx[1], m_ctx[2][7:0], m_ctx[3]};
      @(posedge clk_sys);
      ctx_save <= 1'b0;
      @(negedge clk_sys);
      check("in_handler", in_handler_r, 1'b1);
      cmd(OP_RETURN_HNDL, IRQ_GLOBAL, 0, 0, 1'b0);
      $display("test handler return done");
      cmd_issuer_inst.send(OP_IRQ_ENABLE, 8'd5, 0, 0, 1'b0, 1'b1, MOD_A);
      @(negedge clk_sys);
      check("bad_sum_reply", reply_status_r, STATUS_CSUM_ERR);
      check("bad_sum_en", irq_src_en_r, m_src);
      cmd_issuer_inst.send(OP_IRQ_ENABLE, 8'd5, 0, 0, 1'b0, 1'b0, 8'h07);
      @(negedge clk_sys);
      check("other_addr", reply_valid_r, 1'b0);
      // done, checksum error, new flag and bad bank have all occurred
      reg_read(REG_EVENT_STATUS, d);
      check("status_refused", d, 32'hf);
      $display("test refused frames done");
      reg_write(REG_EVENT_STATUS, 32'hf);
      reg_write(REG_EVENT_MASK, 32'h1);
      reg_read(REG_EVENT_STATUS, d);
      check("status_clr", d, 32'h0);
      cmd(OP_IRQ_ENABLE, 8'd9, 0, 0, 1'b0);
      @(negedge clk_sys);
      check("irq_on", irq_r, 1'b1);
      reg_read(REG_EVENT_STATUS, d);
      check("status_done", d, 32'h1);
      reg_write(REG_EVENT_MASK, 32'h0);
      repeat (2) @(negedge clk_sys);
      check("irq_masked", irq_r, 1'b0);
      reg_write(REG_EVENT_MASK, 32'h1);
      reg_write(REG_EVENT_STATUS, 32'h1);
      repeat (2) @(negedge clk_sys);
      check("irq_cleared", irq_r, 1'b0);
      cmd(OP_CLEAR_FLAGS, CLR_ALL, 0, 0, 1'b1);
      reg_write(REG_EVENT_STATUS, 32'hf);
      @(posedge clk_sys);
      err_set <= 5'h01;
      @(posedge clk_sys);
      err_set <= 5'h00;
      m_flags = 1;
      reg_write(REG_ERROR_FLAGS, 32'h0);
      reg_read(REG_EVENT_STATUS, d);
      check("status_flag", d, 32'h4);
      reg_read(REG_ERROR_FLAGS, d);
      check("reg_flags", d, m_flags);
      reg_read(REG_IRQ_SOURCES, d);
      check("reg_src", d, m_src);
      reg_read(REG_IRQ_GLOBAL, d);
      check("reg_glob", d, m_glob);
      reg_read(8'h14, d);
      check("unmapped", d, 32'h0);
      cmd(OP_IRQ_DISABLE, IRQ_GLOBAL, 0, 0, 1'b1);
      $display("test registers and interrupt done");
      conclude();
   end
endmodule : test_flag_and_irq_command_decode
